// ===== src/tec_counter.sv
// Purpose: 8-bit timer/event counter with apb register access.
// Assumes: one clock sys_clk_i at 50 MHz, reset_i synchronous active high.
// Notes:   zero-wait apb slave; read data is captured in the setup cycle.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tec_counter (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [tec_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [tec_pkg::DATA_W-1:0] pwdata_i,
    output logic [tec_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // pins and side outputs
    input wire logic event_input_pin_i,
    output logic timer_output_pin_o,
    output logic serial_clk_o,
    output logic match_o,
    output logic timer_irq_flag_o
);
    import tec_pkg::*;

    // ------------------------------------------------------------------
    // helpers: pulse sources
    // ------------------------------------------------------------------

    tec_cp_if cp ();  // pulse bundle from the two helpers

    // clock divider taps for the internal count pulse choices
    tec_prescaler u_pre (
        .sys_clk_i (sys_clk_i),
        .reset_i (reset_i),
        .cp (cp)
    );

    // event pin synchroniser and edge finder
    tec_edge_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .reset_i (reset_i),
        .event_input_pin_i (event_input_pin_i),
        .cp (cp)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------

    logic [CNT_W-1:0] mode_q, mode_d;          // event_counter_mode
    logic oe_q, oe_d;                          // timer_output_enable_flag
    logic [CNT_W-1:0] limit_q, limit_d;        // match_limit_reg
    logic [CNT_W-1:0] count_q, count_d;        // count_reg
    logic irq_q, irq_d;                        // timer_irq_flag
    logic flop_q, flop_d;                      // toggle_output_flop
    logic match_q, match_d;                    // registered match pulse
    logic [DATA_W-1:0] rdata_q, rdata_d;       // captured read data

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------

    // true when the address names one of the mapped registers
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        logic r;
        r = 1'b0;
        case (a)
            OFS_MODE, OFS_START, OFS_OUTEN, OFS_MODULO,
            OFS_COUNT, OFS_IRQ, OFS_STATUS: begin
                r = 1'b1;
            end
            default: begin
                r = 1'b0;
            end
        endcase
        return r;
    endfunction : addr_mapped

    // widen an 8-bit value onto the data bus, upper bits read as zero
    function automatic logic [DATA_W-1:0] widen(input logic [CNT_W-1:0] v);
        return {{(DATA_W-CNT_W){1'b0}}, v};
    endfunction : widen

    // place a single flag bit at bit FLAG_BIT of a data word
    function automatic logic [DATA_W-1:0] flag_word(input logic v);
        logic [DATA_W-1:0] w;
        w = DATA_ZERO;
        w[FLAG_BIT] = v;
        return w;
    endfunction : flag_word

    // ------------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------------

    logic setup_ph;   // first cycle of a transfer
    logic access_ph;  // access cycle; always completes at once
    logic wr_en;      // write takes effect at this edge
    logic mapped;     // current address is decoded

    // the slave never stretches a transfer, so pready follows penable
    always_comb begin
        setup_ph = psel_i & ~penable_i;
        access_ph = psel_i & penable_i;
        mapped = addr_mapped(paddr_i);
        wr_en = access_ph & pwrite_i & mapped;
        pready_o = access_ph;
        pslverr_o = access_ph & ~mapped;
    end

    // ------------------------------------------------------------------
    // write strobes per register
    // ------------------------------------------------------------------

    logic wr_mode;    // whole mode register write
    logic wr_start;   // start bit set without touching the rest
    logic wr_oe;      // output enable write
    logic wr_limit;   // modulo write
    logic wr_irq;     // interrupt flag write, sets or clears
    logic start_req;  // a write that sets the start bit

    // one strobe per register, plus the combined start request
    always_comb begin
        wr_mode = wr_en & (paddr_i == OFS_MODE);
        wr_start = wr_en & (paddr_i == OFS_START) & pwdata_i[MODE_START_BIT];
        wr_oe = wr_en & (paddr_i == OFS_OUTEN);
        wr_limit = wr_en & (paddr_i == OFS_MODULO);
        wr_irq = wr_en & (paddr_i == OFS_IRQ);
        // either path that writes one to the start bit restarts the timer
        start_req = wr_start | (wr_mode & pwdata_i[MODE_START_BIT]);
    end

    // ------------------------------------------------------------------
    // count pulse selection
    // ------------------------------------------------------------------

    logic [SEL_W-1:0] sel;  // pulse_select_b2..b0
    logic count_en;         // count enable bit of the mode register
    logic count_pulse;      // selected pulse, gated by enable

    // pick the pulse source; the two forbidden codes give no pulse at all
    always_comb begin
        sel = mode_q[MODE_SEL_LSB +: SEL_W];
        count_en = mode_q[MODE_EN_BIT];
        count_pulse = 1'b0;
        case (sel)
            SEL_EV_RISE: begin
                count_pulse = cp.ev_rise;
            end
            SEL_EV_FALL: begin
                count_pulse = cp.ev_fall;
            end
            SEL_DIV_10: begin
                count_pulse = cp.div_tick[3];
            end
            SEL_DIV_8: begin
                count_pulse = cp.div_tick[2];
            end
            SEL_DIV_6: begin
                count_pulse = cp.div_tick[1];
            end
            SEL_DIV_4: begin
                count_pulse = cp.div_tick[0];
            end
            default: begin
                // codes 010 and 011 are not allowed; hold the count still
                count_pulse = 1'b0;
            end
        endcase
        // with enable low nothing reaches the count register
        count_pulse = count_pulse & count_en;
    end

    // ------------------------------------------------------------------
    // comparator
    // ------------------------------------------------------------------

    logic hit;  // count has reached the modulo value on this pulse

    // comparing only on a pulse gives modulo plus one pulses per match
    always_comb begin
        hit = count_pulse & (count_q == limit_q);
    end

    // ------------------------------------------------------------------
    // mode register next value
    // ------------------------------------------------------------------

    // whole-register write, start-only write, and automatic start clear
    always_comb begin
        mode_d = mode_q;
        if (mode_q[MODE_START_BIT]) begin
            // the start bit reads one for a single cycle, then drops
            mode_d[MODE_START_BIT] = 1'b0;
        end
        if (wr_mode) begin
            mode_d = pwdata_i[CNT_W-1:0];
        end
        if (wr_start) begin
            // the other bits keep their value
            mode_d[MODE_START_BIT] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // output enable and modulo next value
    // ------------------------------------------------------------------

    // both are plain software registers, writable in any mode
    always_comb begin
        oe_d = oe_q;
        limit_d = limit_q;
        if (wr_oe) begin
            oe_d = pwdata_i[FLAG_BIT];
        end
        if (wr_limit) begin
            // all eight bits land in one transfer
            limit_d = pwdata_i[CNT_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // count register, toggle flop, interrupt flag next value
    // ------------------------------------------------------------------

    // start has top priority: a restart in the same cycle as a match wins,
    // so a stale match can never survive the restart
    always_comb begin
        count_d = count_q;
        flop_d = flop_q;
        irq_d = irq_q;
        match_d = 1'b0;
        if (start_req) begin
            count_d = COUNT_ZERO;
            irq_d = 1'b0;
            flop_d = 1'b0;
        end else begin
            // software may set or clear the flag directly
            if (wr_irq) begin
                irq_d = pwdata_i[FLAG_BIT];
            end
            if (hit) begin
                count_d = COUNT_ZERO;
                flop_d = ~flop_q;
                // a match in the same cycle as a software clear still sets
                irq_d = 1'b1;
                match_d = 1'b1;
            end else if (count_pulse) begin
                count_d = count_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------------
    // read data, captured during the setup cycle
    // ------------------------------------------------------------------

    // capturing early keeps prdata on a flop with no wait state; a value
    // changing between setup and access is shown as it was at setup
    always_comb begin
        rdata_d = rdata_q;
        if (setup_ph & ~pwrite_i) begin
            case (paddr_i)
                OFS_MODE: begin
                    rdata_d = widen(mode_q);
                end
                OFS_OUTEN: begin
                    rdata_d = flag_word(oe_q);
                end
                OFS_MODULO: begin
                    rdata_d = widen(limit_q);
                end
                OFS_COUNT: begin
                    rdata_d = widen(count_q);
                end
                OFS_IRQ: begin
                    rdata_d = flag_word(irq_q);
                end
                OFS_STATUS: begin
                    rdata_d = DATA_ZERO;
                    rdata_d[STAT_PIN_BIT] = cp.ev_level;
                    rdata_d[STAT_FLOP_BIT] = flop_q;
                end
                default: begin
                    // start setter and unmapped addresses read as zero
                    rdata_d = DATA_ZERO;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------

    // every flop of the block, loaded by the chip reset; modulo resets to FF, the rest to zero
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            mode_q <= MODE_RESET;
            oe_q <= 1'b0;
            flop_q <= 1'b0;
            limit_q <= MODULO_RESET;
            count_q <= COUNT_ZERO;
            irq_q <= 1'b0;
            match_q <= 1'b0;
            rdata_q <= DATA_ZERO;
        end else begin
            mode_q <= mode_d;
            oe_q <= oe_d;
            flop_q <= flop_d;
            limit_q <= limit_d;
            count_q <= count_d;
            irq_q <= irq_d;
            match_q <= match_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------

    // pin shows the flop only while enabled; flop itself keeps running
    always_comb begin
        timer_output_pin_o = flop_q & oe_q;
        serial_clk_o = flop_q;
        match_o = match_q;
        timer_irq_flag_o = irq_q;
        prdata_o = rdata_q;
    end

endmodule : tec_counter
`default_nettype wire

// ===== src/tec_cp_if.sv
// Purpose: carries count pulse sources from the helpers to the counter core.
// Assumes: all signals on sys_clk_i; ticks and edges are one-cycle pulses, ev_level is a level.
// Notes:   div_tick bit i is the tap with exponent TAP_EXP_i.
`timescale 1ns/10ps
`default_nettype none
interface tec_cp_if;
    import tec_pkg::*;
    logic [TAP_N-1:0] div_tick;  // prescaler tap pulses
    logic ev_rise;               // filtered event pin rising edge
    logic ev_fall;               // filtered event pin falling edge
    logic ev_level;              // filtered event pin level
    modport pre (output div_tick);
    modport sync (output ev_rise, output ev_fall, output ev_level);
    modport core (input div_tick, input ev_rise, input ev_fall, input ev_level);
endinterface : tec_cp_if
`default_nettype wire

// ===== src/tec_edge_sync.sv
// Purpose: brings the event pin into the clock domain and finds its edges.
// Assumes: pin is asynchronous; reset_i synchronous active high.
// Notes:   a new level counts only once the second and third flops agree.
`timescale 1ns/10ps
`default_nettype none
module tec_edge_sync (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic event_input_pin_i,
    tec_cp_if.sync cp
);
    import tec_pkg::*;

    logic s1_q, s2_q, s3_q;  // three-stage synchroniser
    logic lvl_q, lvl_d;      // accepted level
    logic lvl_prev_q;        // accepted level one cycle back

    // next accepted level: change only when stages two and three agree
    always_comb begin
        lvl_d = lvl_q;
        if (s2_q == s3_q) begin
            lvl_d = s3_q;
        end
    end

    // synchroniser and level registers
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
            lvl_prev_q <= 1'b0;
        end else begin
            s1_q <= event_input_pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
            lvl_prev_q <= lvl_q;
        end
    end

    // single-cycle edge pulses, so each edge counts exactly once
    always_comb begin
        cp.ev_rise = lvl_q & ~lvl_prev_q;
        cp.ev_fall = ~lvl_q & lvl_prev_q;
        cp.ev_level = lvl_q;
    end

endmodule : tec_edge_sync
`default_nettype wire

// ===== src/tec_pkg.sv
// Purpose: constants and types shared by the timer/event counter design files.
// Assumes: 32-bit APB data, one aligned word per register, byte addresses below.
// Notes:   only definitions live here; no logic.
package tec_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;   // apb byte address width
    localparam int unsigned DATA_W = 32;  // apb data width
    localparam int unsigned CNT_W = 8;    // count and modulo width
    localparam int unsigned PRE_W = 10;   // prescaler width, largest divide 2^10
    localparam int unsigned TAP_N = 4;    // number of prescaler taps

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;    // event_counter_mode
    localparam logic [ADDR_W-1:0] OFS_START = 8'h04;   // write-only start setter
    localparam logic [ADDR_W-1:0] OFS_OUTEN = 8'h08;   // timer_output_enable_flag
    localparam logic [ADDR_W-1:0] OFS_MODULO = 8'h0C;  // match_limit_reg
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h10;   // count_reg, read only
    localparam logic [ADDR_W-1:0] OFS_IRQ = 8'h14;     // timer_irq_flag
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;  // pin level and flop state

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned MODE_EN_BIT = 2;     // count enable
    localparam int unsigned MODE_START_BIT = 3;  // start request
    localparam int unsigned MODE_SEL_LSB = 4;    // pulse_select_b0
    localparam int unsigned SEL_W = 3;           // pulse_select_b0..b2
    localparam int unsigned FLAG_BIT = 0;        // single-bit registers
    localparam int unsigned STAT_PIN_BIT = 0;    // filtered event pin level
    localparam int unsigned STAT_FLOP_BIT = 1;   // toggle_output_flop

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] MODE_RESET = 8'h00;
    localparam logic [CNT_W-1:0] MODULO_RESET = 8'hFF;
    localparam logic [CNT_W-1:0] COUNT_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // count pulse select codes and prescaler tap exponents
    // ------------------------------------------------------------------
    typedef enum logic [SEL_W-1:0] {
        SEL_EV_RISE = 3'b000,
        SEL_EV_FALL = 3'b001,
        SEL_DIV_10 = 3'b100,
        SEL_DIV_8 = 3'b101,
        SEL_DIV_6 = 3'b110,
        SEL_DIV_4 = 3'b111
    } tec_sel_t;

    localparam int unsigned TAP_EXP_0 = 4;   // tap 0: clock / 2^4
    localparam int unsigned TAP_EXP_1 = 6;   // tap 1: clock / 2^6
    localparam int unsigned TAP_EXP_2 = 8;   // tap 2: clock / 2^8
    localparam int unsigned TAP_EXP_3 = 10;  // tap 3: clock / 2^10

endpackage : tec_pkg

// ===== src/tec_prescaler.sv
// Purpose: free-running divider of the system clock with four tap pulses.
// Assumes: reset_i synchronous active high.
// Notes:   a tap pulses for one cycle each time its low bits wrap.
`timescale 1ns/10ps
`default_nettype none
module tec_prescaler (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    tec_cp_if.pre cp
);
    import tec_pkg::*;

    logic [PRE_W-1:0] div_q;  // divider count
    logic [PRE_W-1:0] div_d;

    // true when the low exp bits are all ones, i.e. the tap is wrapping
    function automatic logic low_ones(input logic [PRE_W-1:0] v, input int unsigned exp);
        logic r;
        r = 1'b1;
        for (int unsigned i = 0; i < PRE_W; i++) begin
            if (i < exp) begin
                r = r & v[i];
            end
        end
        return r;
    endfunction : low_ones

    // next divider value
    always_comb begin
        div_d = div_q + {{(PRE_W-1){1'b0}}, 1'b1};
    end

    // divider register; never stopped, so taps stay phase locked
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // one pulse per 2^exp clocks on each tap
    always_comb begin
        cp.div_tick[0] = low_ones(div_q, TAP_EXP_0);
        cp.div_tick[1] = low_ones(div_q, TAP_EXP_1);
        cp.div_tick[2] = low_ones(div_q, TAP_EXP_2);
        cp.div_tick[3] = low_ones(div_q, TAP_EXP_3);
    end

endmodule : tec_prescaler
`default_nettype wire

// ===== verification/tec_counter_bench.sv
// Purpose: self-checking bench for tec_counter.
// Assumes: zero-wait apb slave, 50 MHz clock.
// Notes:   expected periods come from the select code and modulo value.
`timescale 1ns/10ps
`default_nettype none
module tec_counter_bench;
    import tec_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [ADDR_W-1:0] paddr_i = 8'h00;
    logic [DATA_W-1:0] pwdata_i = 32'h0;
    logic [DATA_W-1:0] prdata_o, rd;
    logic pready_o, pslverr_o, err, event_input_pin_i;
    logic timer_output_pin_o, serial_clk_o, match_o, timer_irq_flag_o;
    int n_mismatch = 0;
    int checked = 0;
    tec_counter i_tec_counter (.*);
    tec_event_src i_tec_event_src (.sys_clk_i, .event_input_pin_o(event_input_pin_i));
    initial forever #10 sys_clk_i = ~sys_clk_i;
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check
    // one apb transfer; ends at the falling edge so outputs have settled
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        // no cycle count assumed: only the watchdog ends a stuck transfer
        do begin
            @(posedge sys_clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(negedge sys_clk_i);
    endtask : apb
    task automatic wait_match(output int t);
        t = 0;
        do begin
            @(posedge sys_clk_i);
            t++;
        end while (match_o !== 1'b1 && t < 5000);
        // a match that never came must not slip through as a pass
        if (match_o !== 1'b1) begin
            n_mismatch++;
            $display("BAD t=%0t match=%0h exp=%0h", $time, match_o, 1'b1);
        end
    endtask : wait_match
    task automatic t_reset();
        apb(0, OFS_MODE, 0);
        check(rd, 32'(MODE_RESET));
        apb(0, OFS_OUTEN, 0);
        check(rd, 32'h0);
        check(serial_clk_o, 1'b0);
        apb(0, OFS_MODULO, 0);
        check(rd, 32'(MODULO_RESET));
    endtask : t_reset
    task automatic t_start();
        apb(1, OFS_MODE, 32'h44);
        apb(1, OFS_START, 32'h08);
        apb(0, OFS_MODE, 0);
        check(rd, 32'h44);
    endtask : t_start
    // rising, falling, then enable low: only the first two may count
    task automatic t_event();
        apb(1, OFS_MODULO, 32'hFF);
        for (int c = 0; c < 3; c++) begin
            apb(1, OFS_MODE, c == 2 ? 32'h08 : {25'h0, c[2:0], 4'hC});
            i_tec_event_src.send(5, 3 + c);
            repeat (8) @(posedge sys_clk_i);
            apb(0, OFS_COUNT, 0);
            check(rd, c == 2 ? 32'h0 : 32'h5);
        end
        apb(1, OFS_COUNT, 32'h55);
        apb(0, OFS_COUNT, 0);
        check(rd, 32'h0);
    endtask : t_event
    task automatic t_irq();
        apb(1, OFS_IRQ, 32'h1);
        check(timer_irq_flag_o, 1'b1);
        apb(1, OFS_IRQ, 32'h0);
        check(timer_irq_flag_o, 1'b0);
        apb(1, OFS_IRQ, 32'h1);
        apb(1, OFS_START, 32'h08);
        check(timer_irq_flag_o, 1'b0);
        apb(0, 8'h40, 0);
        check(err, 1'b1);
        check(rd, 32'h0);
    endtask : t_irq
    // divided clocks, slowest last; period is (modulo + 1) times 2^n
    task automatic t_div();
        int t;
        apb(1, OFS_MODULO, 32'h03);
        apb(1, OFS_OUTEN, 32'h1);
        for (int c = 7; c >= 4; c--) begin
            apb(1, OFS_MODE, {25'h0, c[2:0], 4'hC});
            wait_match(t);
            check(serial_clk_o, 1'b1);
            check(timer_output_pin_o, 1'b1);
            check(timer_irq_flag_o, 1'b1);
            wait_match(t);
            check(t, 32'h4 << (4 + 2 * (7 - c)));
        end
        apb(1, OFS_OUTEN, 32'h0);
        wait_match(t);
        check(timer_output_pin_o, 1'b0);
        check(serial_clk_o, 1'b1);
        apb(0, OFS_STATUS, 0);
        check(rd, 32'h2);
    endtask : t_div
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_start();
        t_event();
        t_irq();
        t_div();
        test_done();
    end
endmodule : tec_counter_bench
`default_nettype wire

// ===== verification/tec_counter_monitor.sv
// Purpose: checks the port behaviour of tec_counter.
// Assumes: one clock, reset_i synchronous and active high.
// Notes:   bound to every tec_counter instance.
`timescale 1ns/10ps
`default_nettype none
module tec_counter_monitor (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [tec_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [tec_pkg::DATA_W-1:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic timer_output_pin_o,
    input wire logic serial_clk_o,
    input wire logic match_o,
    input wire logic timer_irq_flag_o
);
    import tec_pkg::*;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    logic acc_w;  // write taken at this edge
    logic start_w;  // write that requests a start
    logic clr_w;  // write that may legally drop the flag
    assign acc_w = psel_i && penable_i && pwrite_i;
    assign start_w = acc_w && pwdata_i[MODE_START_BIT]
        && (paddr_i == OFS_MODE || paddr_i == OFS_START);
    assign clr_w = start_w || (acc_w && paddr_i == OFS_IRQ);
    AST_PREADY: assert property (pready_o == (psel_i && penable_i))
        else $error("pready not zero wait");
    AST_SLVERR: assert property (psel_i && penable_i && paddr_i > OFS_STATUS |-> pslverr_o)
        else $error("unmapped access without error");
    AST_MATCH_TOGGLE: assert property (match_o |-> serial_clk_o != $past(serial_clk_o))
        else $error("flop did not invert on match");
    AST_MATCH_IRQ: assert property (match_o |-> timer_irq_flag_o)
        else $error("match left flag clear");
    AST_MATCH_ONE: assert property (match_o |=> !match_o)
        else $error("match longer than one cycle");
    AST_PIN_GATE: assert property (timer_output_pin_o |-> serial_clk_o)
        else $error("pin high while flop low");
    AST_START: assert property (start_w |=> !timer_irq_flag_o && !serial_clk_o && !match_o)
        else $error("start did not clear flag and flop");
    AST_IRQ_SET: assert property (acc_w && paddr_i == OFS_IRQ && pwdata_i[FLAG_BIT]
        |=> timer_irq_flag_o)
        else $error("software set of flag lost");
    AST_IRQ_HOLD: assert property ($fell(timer_irq_flag_o) |-> $past(clr_w))
        else $error("flag dropped by itself");
endmodule : tec_counter_monitor
bind tec_counter tec_counter_monitor i_tec_counter_monitor (.*);
`default_nettype wire

// ===== verification/tec_event_src.sv
// Purpose: external event source driving the event pin.
// Assumes: called from the bench thread, changes just after rising edges.
// Notes:   the pin is actively driven, so it holds its level between pulses.
`timescale 1ns/10ps
`default_nettype none
module tec_event_src (
    input wire logic sys_clk_i,
    output logic event_input_pin_o
);
    initial event_input_pin_o = 1'b0;
    // n pulses, each high then low for hold clocks; hold sets fast or slow
    task automatic send(input int n, input int hold);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk_i);
            event_input_pin_o <= 1'b1;
            repeat (hold) @(posedge sys_clk_i);
            event_input_pin_o <= 1'b0;
            repeat (hold) @(posedge sys_clk_i);
        end
    endtask : send
endmodule : tec_event_src
`default_nettype wire
